// ===== include/pdl_pkg.sv
// constants and types shared by the duty-limit / compensator block
package pdl_pkg;

    // ------------------------------------------------------------------
    // register map (byte pointer values on the serial bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] PDL_REG_INTLV  = 8'h04;  // interleave step, bits 3:0
    localparam logic [7:0] PDL_REG_DLIM   = 8'h09;  // duty_cycle_limit_reg
    localparam logic [7:0] PDL_REG_PROP   = 8'h0A;  // prop_coeff_reg
    localparam logic [7:0] PDL_REG_INTEG  = 8'h0B;  // integ_coeff_reg
    localparam logic [7:0] PDL_REG_DERIV  = 8'h0C;  // deriv_coeff_reg
    localparam logic [7:0] PDL_REG_ROLL   = 8'h0D;  // rolloff_coeff_reg
    localparam logic [7:0] PDL_REG_IDENT  = 8'h0E;  // bit 0 plant identification enable
    localparam logic [7:0] PDL_REG_CAPT   = 8'h0F;  // captured response, read only

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int         PDL_DLIM_LSB   = 2;      // duty_limit_field sits in 7:2
    localparam int         PDL_DLIM_W     = 6;
    localparam logic [7:0] PDL_DLIM_RST   = 8'hE8;  // 111010 in bits 7:2
    localparam logic [3:0] PDL_INTLV_RST  = 4'h0;
    localparam logic [7:0] PDL_PROP_RST   = 8'h10;
    localparam logic [7:0] PDL_INTEG_RST  = 8'h02;
    localparam logic [7:0] PDL_DERIV_RST  = 8'h00;
    localparam logic [7:0] PDL_ROLL_RST   = 8'h80;
    localparam logic [6:0] PDL_DEV_ADDR   = 7'h20;  // bus address, arbitrary
    localparam logic [6:0] PDL_PRBS_SEED  = 7'h7F;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         PDL_CLK_HZ     = 20_000_000;
    localparam int         PDL_PWM_HZ     = 500_000;
    localparam int         PDL_PERIOD_CYC = PDL_CLK_HZ / PDL_PWM_HZ;  // 40
    localparam int         PDL_INTLV_DIV  = 16;     // 22.5 degree steps
    localparam int         PDL_FRAC_SH    = 6;      // duty in 64ths
    localparam int         PDL_PID_SH     = 8;      // pid sum scaling

    typedef logic signed [19:0] pdl_acc_t;

endpackage : pdl_pkg

// ===== rtl/pdl_prbs.sv
// pseudo-random bit source used for plant identification
`timescale 1ns/10ps
module pdl_prbs #(
    parameter int         W    = 7,
    parameter logic [6:0] SEED = pdl_pkg::PDL_PRBS_SEED
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic step,
    output logic      bit_out
);
    import pdl_pkg::*;

    logic [W-1:0] lfsr_reg;

    // ------------------------------------------------------------------
    // maximal-length shift register, x^7 + x^6 + 1
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lfsr_reg <= W'(SEED);
        end else if (step) begin
            lfsr_reg <= {lfsr_reg[W-2:0], lfsr_reg[W-1] ^ lfsr_reg[W-2]};
        end
    end

    assign bit_out = lfsr_reg[W-1];  // flop output

    property p_prbs_alive;
        @(posedge sys_clk) disable iff (!rstn)
        step |=> (lfsr_reg != '0) && (lfsr_reg != $past(lfsr_reg));
    endproperty
    a_prbs_alive : assert property (p_prbs_alive) else $error("prbs stuck");

endmodule : pdl_prbs

// ===== rtl/pdl_core.sv
// pwm duty limiter, pid compensator, interleave timing and serial register port
`timescale 1ns/10ps
module pdl_core #(
    parameter int PERIOD_CYC = pdl_pkg::PDL_PERIOD_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       sync_line,
    input  wire logic [7:0] vout_code,
    input  wire logic [7:0] vref_code,
    input  wire logic       sample_valid,
    input  wire logic [5:0] nominal_duty,
    output logic            hs_drive
);
    import pdl_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD} pdl_bus_e;

    // ------------------------------------------------------------------
    // serial register port
    // ------------------------------------------------------------------
    pdl_bus_e   st_reg;
    logic       scl_q_reg, sda_q_reg, ack_reg, drv_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg, tx_reg, ptr_reg;
    logic       scl_rise, scl_fall, bus_start, bus_stop, byte_done, wr_stb;
    logic [7:0] rd_data;

    // register storage
    logic [3:0] intlv_reg;
    logic [5:0] dlim_reg;
    logic [7:0] prop_reg, integ_reg, deriv_reg, roll_reg, capt_reg;
    logic       ident_reg;

    assign scl_rise  = scl_in & ~scl_q_reg;
    assign scl_fall  = ~scl_in & scl_q_reg;
    assign bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign bus_stop  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign byte_done = scl_fall & ~ack_reg & (bit_reg == 4'h8);
    assign wr_stb    = byte_done & (st_reg == ST_WR);
    assign sda_out   = 1'b0;        // open drain, only ever pulls low
    assign sda_oe_n  = ~drv_reg;

    // read mux; unmapped pointers and unbacked bits read zero
    assign rd_data = (ptr_reg == PDL_REG_INTLV) ? {4'h0, intlv_reg} :
                     (ptr_reg == PDL_REG_DLIM)  ? {dlim_reg, 2'b00} :
                     (ptr_reg == PDL_REG_PROP)  ? prop_reg :
                     (ptr_reg == PDL_REG_INTEG) ? integ_reg :
                     (ptr_reg == PDL_REG_DERIV) ? deriv_reg :
                     (ptr_reg == PDL_REG_ROLL)  ? roll_reg :
                     (ptr_reg == PDL_REG_IDENT) ? {7'h00, ident_reg} :
                     (ptr_reg == PDL_REG_CAPT)  ? capt_reg : 8'h00;

    // line history for edge and start/stop detection
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    // byte framing, acknowledge and read shifting
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg  <= ST_IDLE;
            bit_reg <= 4'h0;
            sh_reg  <= 8'h00;
            tx_reg  <= 8'h00;
            ptr_reg <= 8'h00;
            ack_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (bus_start) begin
            st_reg  <= ST_DEV;
            bit_reg <= 4'h0;
            ack_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (bus_stop) begin
            st_reg  <= ST_IDLE;
            drv_reg <= 1'b0;
        end else if (st_reg != ST_IDLE) begin
            if (scl_rise && !ack_reg) begin
                sh_reg  <= {sh_reg[6:0], sda_in};
                bit_reg <= bit_reg + 4'h1;
            end else if (scl_rise && ack_reg && st_reg == ST_RD && sda_in) begin
                st_reg  <= ST_IDLE;    // master nack ends the read
            end else if (scl_fall && ack_reg) begin
                ack_reg <= 1'b0;
                bit_reg <= 4'h0;
                tx_reg  <= rd_data;
                drv_reg <= (st_reg == ST_RD) && !rd_data[7];
            end else if (byte_done) begin
                ack_reg <= 1'b1;
                drv_reg <= (st_reg != ST_RD);
                unique case (st_reg)
                    ST_DEV: begin
                        if (sh_reg[7:1] == PDL_DEV_ADDR) begin
                            st_reg <= sh_reg[0] ? ST_RD : ST_PTR;
                        end else begin
                            st_reg  <= ST_IDLE;
                            ack_reg <= 1'b0;
                            drv_reg <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        ptr_reg <= sh_reg;
                        st_reg  <= ST_WR;
                    end
                    ST_WR:   ptr_reg <= ptr_reg + 8'h01;
                    ST_RD:   ptr_reg <= ptr_reg + 8'h01;
                    ST_IDLE: st_reg <= ST_IDLE;
                endcase
            end else if (scl_fall && st_reg == ST_RD && bit_reg != 4'h0) begin
                tx_reg  <= {tx_reg[6:0], 1'b0};
                drv_reg <= !tx_reg[6];
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // writes land on the byte-complete edge, before the acknowledge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intlv_reg <= PDL_INTLV_RST;
            dlim_reg  <= PDL_DLIM_RST[7:PDL_DLIM_LSB];
            prop_reg  <= PDL_PROP_RST;
            integ_reg <= PDL_INTEG_RST;
            deriv_reg <= PDL_DERIV_RST;
            roll_reg  <= PDL_ROLL_RST;
            ident_reg <= 1'b0;
        end else if (wr_stb) begin
            if (ptr_reg == PDL_REG_INTLV) intlv_reg <= sh_reg[3:0];
            if (ptr_reg == PDL_REG_DLIM)  dlim_reg  <= sh_reg[7:PDL_DLIM_LSB];
            if (ptr_reg == PDL_REG_PROP)  prop_reg  <= sh_reg;
            if (ptr_reg == PDL_REG_INTEG) integ_reg <= sh_reg;
            if (ptr_reg == PDL_REG_DERIV) deriv_reg <= sh_reg;
            if (ptr_reg == PDL_REG_ROLL)  roll_reg  <= sh_reg;
            if (ptr_reg == PDL_REG_IDENT) ident_reg <= sh_reg[0];
        end
    end

    // ------------------------------------------------------------------
    // interleave timing against the sync line
    // ------------------------------------------------------------------
    logic       sync_q_reg, sync_fall, cyc_start;
    logic [7:0] phase_reg, pwm_cnt_reg, intlv_ofs;

    assign sync_fall = sync_q_reg & ~sync_line;
    assign intlv_ofs = 8'((32'(intlv_reg) * PERIOD_CYC) / PDL_INTLV_DIV);
    assign cyc_start = (phase_reg == intlv_ofs);

    // phase restarts at every sync fall; pwm cycle starts at the offset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync_q_reg  <= 1'b1;
            phase_reg   <= 8'h00;
            pwm_cnt_reg <= 8'h00;
        end else begin
            sync_q_reg  <= sync_line;
            phase_reg   <= (sync_fall || phase_reg == 8'(PERIOD_CYC - 1)) ? 8'h00
                         : phase_reg + 8'h01;
            pwm_cnt_reg <= (cyc_start || pwm_cnt_reg == 8'(PERIOD_CYC - 1)) ? 8'h00
                         : pwm_cnt_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // pid compensator, run once per pwm cycle
    // ------------------------------------------------------------------
    logic signed [8:0] err, err_prev_reg;
    pdl_acc_t          p_term, i_next, d_raw, d_next, u_val;
    pdl_acc_t          integ_acc_reg, d_reg;
    logic [5:0]        pid_duty_reg, duty_sel;
    logic [7:0]        duty_cmp_reg, limit_cmp;
    logic              prbs_bit;

    assign err    = $signed({1'b0, vref_code}) - $signed({1'b0, vout_code});
    assign p_term = pdl_acc_t'($signed(prop_reg) * err);
    assign i_next = integ_acc_reg + pdl_acc_t'($signed(integ_reg) * err);
    assign d_raw  = pdl_acc_t'($signed(deriv_reg) * (10'(err) - 10'(err_prev_reg)));
    // first-order roll-off: trades derivative edge for noise rejection
    assign d_next = d_reg + pdl_acc_t'((30'(d_raw - d_reg) * $signed({1'b0, roll_reg}))
                                       >>> PDL_PID_SH);  // wide product, cut after shift
    assign u_val  = pdl_acc_t'(nominal_duty)
                  + ((p_term + integ_acc_reg + d_reg) >>> PDL_PID_SH)
                  + (ident_reg ? (prbs_bit ? 20'sd1 : -20'sd1) : 20'sd0);

    // clamp to 0..63 then take the lesser of pid and limit
    assign duty_sel  = (pid_duty_reg > dlim_reg) ? dlim_reg : pid_duty_reg;
    assign limit_cmp = 8'((32'(dlim_reg) * PERIOD_CYC) >> PDL_FRAC_SH);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err_prev_reg  <= '0;
            integ_acc_reg <= '0;
            d_reg         <= '0;
            pid_duty_reg  <= 6'h00;
            duty_cmp_reg  <= 8'h00;
        end else if (cyc_start) begin
            err_prev_reg  <= err;
            integ_acc_reg <= i_next;
            d_reg         <= d_next;
            pid_duty_reg  <= (u_val < 0) ? 6'h00 : (u_val > 20'sd63) ? 6'h3F
                           : u_val[5:0];
            duty_cmp_reg  <= 8'((32'(duty_sel) * PERIOD_CYC) >> PDL_FRAC_SH);
        end
    end

    pdl_prbs u_prbs (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .step    (cyc_start),
        .bit_out (prbs_bit)
    );

    // response capture; the host polls it while identification runs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capt_reg <= 8'h00;
        end else if (ident_reg && sample_valid) begin
            capt_reg <= vout_code;
        end
    end

    // high-side drive; no sharing path exists anywhere in this block
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hs_drive <= 1'b0;
        end else begin
            hs_drive <= (pwm_cnt_reg < duty_cmp_reg);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_dlim_write;
        wr_stb && ptr_reg == PDL_REG_DLIM;
    endsequence
    property p_dlim_store;
        @(posedge sys_clk) disable iff (!rstn)
        s_dlim_write |=> dlim_reg == $past(sh_reg[7:2]);
    endproperty
    a_dlim_store : assert property (p_dlim_store) else $error("limit not stored");
    property p_low_bits_zero;
        @(posedge sys_clk) disable iff (!rstn)
        (ptr_reg == PDL_REG_DLIM) |-> rd_data[1:0] == 2'b00;
    endproperty
    a_low_bits_zero : assert property (p_low_bits_zero) else $error("low bits set");
    property p_limit_applied;
        @(posedge sys_clk) disable iff (!rstn)
        cyc_start |=> duty_cmp_reg <= $past(limit_cmp);
    endproperty
    a_limit_applied : assert property (p_limit_applied) else $error("limit ignored");
    property p_never_above;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(hs_drive) |-> ##[1:40] !hs_drive;
    endproperty
    a_never_above : assert property (p_never_above) else $error("on-time overrun");
    property p_coeff_store;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_stb && ptr_reg == PDL_REG_PROP) |=> prop_reg == $past(sh_reg);
    endproperty
    a_coeff_store : assert property (p_coeff_store) else $error("coeff lost");
    property p_capture;
        @(posedge sys_clk) disable iff (!rstn)
        (ident_reg && sample_valid) |=> capt_reg == $past(vout_code);
    endproperty
    a_capture : assert property (p_capture) else $error("response not captured");
    property p_interleave;
        @(posedge sys_clk) disable iff (!rstn)
        cyc_start |=> pwm_cnt_reg == 8'h00;
    endproperty
    a_interleave : assert property (p_interleave) else $error("cycle start late");
    property p_compare;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 hs_drive == ($past(pwm_cnt_reg) < $past(duty_cmp_reg));
    endproperty
    a_compare : assert property (p_compare) else $error("drive mismatch");

endmodule : pdl_core

// ===== sim/pdl_host_model.sv
// host model: serial register master that drives scl and releases or pulls sda
`timescale 1ns/10ps
module pdl_host_model (
    input  wire logic sys_clk,
    input  wire logic sda_wire,
    output logic      scl_o,
    output logic      sda_o
);
    import pdl_pkg::*;
    localparam int H = 3;  // half bit time in sys_clk, above the 2 clock minimum

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // ------------------------------------------------------------------
    // bit level: all changes just after the falling sys_clk edge
    // ------------------------------------------------------------------
    task automatic hold();
        repeat (H) @(negedge sys_clk);
    endtask : hold

    // data set while scl low, sampled at the end of the high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_o = b;
        hold();
        scl_o = 1'b1;
        hold();
        s = sda_wire;
        scl_o = 1'b0;
    endtask : clk_bit

    // works from idle and as a repeated start
    task automatic start();
        sda_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b0;
        hold();
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        sda_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b1;
        hold();
    endtask : stop

    task automatic put_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack_n);
    endtask : put_byte

    // ------------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------------
    // burst write; the device moves the pointer on after each byte
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d[$], output logic ack_n);
        logic k;
        start();
        put_byte({PDL_DEV_ADDR, 1'b0}, ack_n);
        put_byte(a, k);
        ack_n = ack_n | k;
        foreach (d[i]) begin
            put_byte(d[i], k);
            ack_n = ack_n | k;
        end
        stop();
    endtask : reg_write

    // single byte read ended by a nack
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        put_byte({PDL_DEV_ADDR, 1'b0}, k);
        put_byte(a, k);
        start();
        put_byte({PDL_DEV_ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b1, k);
        stop();
    endtask : reg_read

    task automatic probe(input logic [6:0] addr, output logic ack_n);
        start();
        put_byte({addr, 1'b0}, ack_n);
        stop();
    endtask : probe
endmodule : pdl_host_model

// ===== sim/tb_top.sv
// self-checking bench for the duty limiter, compensator and interleave timing
`timescale 1ns/10ps
module tb_top;
    import pdl_pkg::*;
    localparam int PER = 40;
    localparam int TMO = 60000;  // cycles; the sequence needs about a quarter
    logic       sys_clk, rstn, sync_line, sample_valid, sync_run;
    logic [7:0] vout_code, vref_code, rd, v;
    logic [5:0] nominal_duty;
    logic       ack_n;
    wire logic  scl_w, sda_h, sda_out, sda_oe_n, hs_drive, sda_w;
    int         n_fail, n_compared, cyc, sph, d0, dk, model[256], mask[256];
    logic [7:0] lims[6];

    // open drain wire with pull-up: low if either party pulls
    assign sda_w = sda_h & (sda_oe_n | sda_out);

    pdl_core #(.PERIOD_CYC(PER)) i_pdl_core (
        .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sync_line(sync_line),
        .vout_code(vout_code), .vref_code(vref_code), .sample_valid(sample_valid),
        .nominal_duty(nominal_duty), .hs_drive(hs_drive));
    pdl_host_model i_pdl_host_model (
        .sys_clk(sys_clk), .sda_wire(sda_w), .scl_o(scl_w), .sda_o(sda_h));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // sync line of one switching period, falling mid-period
    always @(negedge sys_clk) begin
        if (sync_run) begin
            sph <= (sph == PER - 1) ? 0 : sph + 1;
            sync_line <= (sph < PER / 2);
        end
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            n_fail++;
            $display("mismatch at %0t: run did not finish in time", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // write through the host and mirror it in the register model
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input bit chk);
        i_pdl_host_model.reg_write(a, d, ack_n);
        if (chk) check({7'h00, ack_n}, 8'h00, "write ack");
        foreach (d[i]) begin
            if (a + i != 15) model[(a + i) % 256] = d[i] & mask[(a + i) % 256];
        end
    endtask : wr

    task automatic rdc(input logic [7:0] a);
        i_pdl_host_model.reg_read(a, rd);
        check(rd, 8'(model[a]), "register read");
    endtask : rdc

    // high time over two whole periods once the new limit has settled
    task automatic duty_check(input logic [7:0] lim);
        int hi;
        hi = 0;
        repeat (2 * PER + 4) @(negedge sys_clk);
        repeat (2 * PER) begin
            @(negedge sys_clk);
            if (hs_drive === 1'b1) hi++;
        end
        check(8'(hi), 8'(2 * (((lim >> 2) * PER) >> 6)), "high time");
    endtask : duty_check

    // clocks from a sync fall to the next rise of the high side drive
    task automatic rise_delay(output int d);
        logic last;
        @(negedge sync_line);
        last = hs_drive;
        d = 0;
        repeat (2 * PER) begin
            @(posedge sys_clk);
            #1;
            d++;
            if (hs_drive === 1'b1 && last === 1'b0) break;
            last = hs_drive;
        end
    endtask : rise_delay

    task automatic pulse(input logic [7:0] val);
        vout_code = val;
        sample_valid = 1'b1;
        @(negedge sys_clk);
        sample_valid = 1'b0;
        @(negedge sys_clk);
    endtask : pulse

    task automatic stop_test();
        $display("counts: compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        sph = 0;
        rstn = 1'b0;
        sync_line = 1'b1;
        sync_run = 1'b0;
        sample_valid = 1'b0;
        vout_code = 8'h00;
        vref_code = 8'hFF;
        nominal_duty = 6'h3F;  // keeps the compensator pinned at full scale
        for (int i = 0; i < 256; i++) model[i] = 0;
        for (int i = 0; i < 256; i++) mask[i] = 0;
        mask[4] = 'h0F;
        mask[9] = 'hFC;
        for (int i = 10; i < 14; i++) mask[i] = 'hFF;
        mask[14] = 'h01;
        model[9] = PDL_DLIM_RST;
        model[10] = PDL_PROP_RST;
        model[11] = PDL_INTEG_RST;
        model[12] = PDL_DERIV_RST;
        model[13] = PDL_ROLL_RST;
        void'($urandom(32'h99C07E26));
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        sync_run = 1'b1;

        for (int a = 4; a < 16; a++) rdc(8'(a));
        i_pdl_host_model.probe(7'(PDL_DEV_ADDR + 7'h01), ack_n);
        check({7'h00, ack_n}, 8'h01, "foreign address acked");
        $display("test reset and map done");

        lims = '{8'h00, 8'h07, 8'hFF, 8'h80, 8'h00, 8'h00};
        lims[4] = 8'($urandom);
        lims[5] = 8'($urandom);
        foreach (lims[i]) begin
            wr(8'h09, {lims[i]}, 1'b1);
            rdc(8'h09);
            duty_check(lims[i]);
        end
        $display("test duty limit done");

        // zero error while random gains are loaded, so the integrator cannot wind up
        vout_code = vref_code;
        for (int i = 0; i < 4; i++) lims[i] = 8'($urandom);
        wr(8'h0A, {lims[0], lims[1], lims[2], lims[3]}, 1'b1);
        for (int a = 10; a < 14; a++) rdc(8'(a));
        wr(8'h0A, {PDL_PROP_RST, PDL_INTEG_RST, PDL_DERIV_RST, PDL_ROLL_RST}, 1'b1);
        vout_code = 8'h00;
        $display("test coefficients done");

        wr(8'h09, {8'h80}, 1'b1);
        for (int k = 0; k < 16; k++) begin
            wr(8'h04, {8'(k)}, 1'b1);
            repeat (2 * PER) @(negedge sys_clk);
            rise_delay(dk);
            if (k == 0) d0 = dk;
            check(8'(dk), 8'((d0 + (k * PER) / 16 - 1) % PER + 1), "phase delay");
        end
        rdc(8'h04);
        $display("test interleave done");

        wr(8'h0E, {8'h01}, 1'b1);
        repeat (3) begin
            v = 8'($urandom);
            pulse(v);
        end
        model[15] = v;
        rdc(8'h0F);
        duty_check(8'h80);
        wr(8'h0F, {8'h5A}, 1'b0);
        rdc(8'h0F);
        wr(8'h0E, {8'h00}, 1'b1);
        pulse(~v);
        rdc(8'h0F);
        rdc(8'h0E);
        $display("test identification done");
        stop_test();
    end
endmodule : tb_top
